// ===== hdl/fcp_interp.sv
// How it works
// - new command accepted any time in command phase
// - check first byte; unknown code raises interrupt
// - sense interrupt then returns invalid command status
// - cylinder is unsigned eight bits, 0..255
// - perpendicular flag one marks drive perpendicular
// - direction zero steps out, one steps in
// - size code zero: 128 bytes, length parameter counts
// - read past length: read sector, withhold excess
// - write past length: pad sector with zeros
// - crc spans full physical sector
// - count mode makes verify length sectors per track
// - queue enable active low, disabled by default
// - implied seek before read/write with cylinder
// - final sector number ends the track sequence
// - gap bits alter second gap in perpendicular mode
// - format writes fill pattern in every data field
// - nonzero code: 128 shifted by code, to 7
`timescale 1ns/1ps
module fcp_interp
  import fcp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic byte_wr,
  input wire logic [7:0] byte_in,
  input wire logic result_rd,
  input wire logic exec_done,
  input wire logic [7:0] exec_st0,
  input wire logic [13:0] exec_byte_idx,
  input wire logic [7:0] cur_sector,
  output logic request_for_master,
  output logic transfer_direction,
  output logic [7:0] result_byte,
  output logic irq,
  output logic cmd_start,
  output logic [7:0] cmd_code,
  output logic implied_seek_req,
  output logic [7:0] cylinder,
  output logic [1:0] drive_pick,
  output logic drive_index,
  output logic step_inward,
  output logic [1:0] perp_drive_flags,
  output logic [1:0] gap2_adjust,
  output logic [7:0] special_length_limit,
  output logic [2:0] sector_size_code,
  output logic [14:0] sector_bytes,
  output logic [14:0] host_bytes,
  output logic [14:0] crc_bytes,
  output logic count_mode_enable,
  output logic [7:0] sectors_per_track,
  output logic queue_enable_low,
  output logic implied_positioning_enable,
  output logic [7:0] final_sector_number,
  output logic [7:0] fill_pattern,
  output logic exec_pass_host,
  output logic exec_pad_zero,
  output logic track_end
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // {valid, needs execution, parameter count}
  function automatic logic [5:0] cmd_info(input logic [7:0] c);
    logic [5:0] r;
    r = {1'b1, 1'b0, CNT_NONE};
    unique case (c[4:0])
      OP_READ, OP_READ_DEL, OP_READ_TRACK, OP_WRITE, OP_WRITE_DEL,
      OP_VERIFY, OP_SCAN_EQ, OP_SCAN_LE, OP_SCAN_HE: r = {2'b11, CNT_RW};
      OP_FORMAT: r = {2'b11, CNT_FORMAT};
      OP_SEEK: r = {2'b11, CNT_TWO};
      OP_RECAL, OP_READ_ID: r = {2'b11, CNT_ONE};
      OP_SENSE_DRV, OP_PERP: r = {2'b10, CNT_ONE};
      OP_SPECIFY: r = {2'b10, CNT_TWO};
      OP_CONFIGURE: r = {2'b10, CNT_CONFIG};
      OP_SENSE_INT, OP_VERSION, OP_DUMPREG, OP_LOCK: r = {2'b10, CNT_NONE};
      default: r = {1'b0, 1'b0, CNT_NONE};
    endcase
    return r;
  endfunction : cmd_info

  function automatic logic is_rw(input logic [7:0] c);
    logic r;
    r = 1'b0;
    unique case (c[4:0])
      OP_READ, OP_READ_DEL, OP_READ_TRACK, OP_WRITE, OP_WRITE_DEL,
      OP_VERIFY, OP_SCAN_EQ, OP_SCAN_LE, OP_SCAN_HE: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : is_rw

  // read class only: verify and scans move no data to the host
  function automatic logic is_read(input logic [7:0] c);
    logic r;
    r = 1'b0;
    unique case (c[4:0])
      OP_READ, OP_READ_DEL, OP_READ_TRACK: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : is_read

  function automatic logic is_write(input logic [7:0] c);
    return (c[4:0] == OP_WRITE) || (c[4:0] == OP_WRITE_DEL);
  endfunction : is_write

  function automatic logic [14:0] sect_len(input logic [2:0] n);
    return SECT_BASE << n;
  endfunction : sect_len

  // ----------------------------------------
  // state
  // ----------------------------------------
  fcp_regs_s r_reg;
  fcp_regs_s r_next;
  logic [5:0] info;
  logic [14:0] xfer_len;
  logic [3:0] idx;
  logic [5:0] pinfo;

  assign info = cmd_info(byte_in);
  // decode of the held command, used when its last parameter lands
  assign pinfo = cmd_info(r_reg.cmd);
  assign idx = r_reg.pidx + 4'h1;
  // size code zero: length byte sets the transfer, else full sector
  assign xfer_len = (r_reg.n == 3'h0) ? {7'h00, r_reg.len_limit} : sect_len(r_reg.n);

  always_comb begin
    r_next = r_reg;
    r_next.start = 1'b0;
    r_next.seek_req = 1'b0;
    // byte is taken on the edge it is written; busy holds one cycle after
    r_next.busy = byte_wr && (r_reg.state == ST_CMD || r_reg.state == ST_PARAM);
    unique case (r_reg.state)
      ST_CMD: begin
        if (byte_wr) begin
          r_next.cmd = byte_in;
          r_next.pidx = 4'h0;
          r_next.pcnt = info[3:0];
          if (!info[5]) begin
            // unknown code: no parameters, flag it
            r_next.irq = 1'b1;
            r_next.st0 = ST0_INVALID;
          end else if (byte_in[4:0] == OP_SENSE_INT) begin
            r_next.state = ST_RESULT;
          end else if (byte_in[4:0] == OP_LOCK || info[3:0] != CNT_NONE) begin
            if (info[3:0] != CNT_NONE) begin
              r_next.state = ST_PARAM;
            end
          end
        end
      end
      ST_PARAM: begin
        if (byte_wr) begin
          r_next.pidx = idx;
          if (is_rw(r_reg.cmd) || r_reg.cmd[4:0] == OP_FORMAT ||
              r_reg.cmd[4:0] == OP_SEEK || r_reg.cmd[4:0] == OP_RECAL ||
              r_reg.cmd[4:0] == OP_READ_ID || r_reg.cmd[4:0] == OP_SENSE_DRV) begin
            if (idx == 4'h1) begin
              r_next.drive = byte_in[1:0];
            end
          end
          if (is_rw(r_reg.cmd)) begin
            if (idx == 4'h1 && r_reg.cmd[4:0] == OP_VERIFY) begin
              r_next.cnt_mode = byte_in[BIT_CNT_MODE];
            end
            if (idx == 4'h2) begin
              r_next.cyl = byte_in;
            end
            if (idx == 4'h5) begin
              // codes above 7 have no size; hold them at the largest one
              if (byte_in > {5'h00, N_MAX}) begin
                r_next.n = N_MAX;
              end else begin
                r_next.n = byte_in[2:0];
              end
            end
            if (idx == 4'h6) begin
              r_next.last_sec = byte_in;
            end
            if (idx == 4'h8) begin
              if (r_reg.cmd[4:0] == OP_VERIFY && r_reg.cnt_mode) begin
                r_next.spt = byte_in;
              end else begin
                r_next.len_limit = byte_in;
              end
            end
          end else if (r_reg.cmd[4:0] == OP_FORMAT) begin
            if (idx == 4'h2) begin
              r_next.n = byte_in[2:0];
            end
            if (idx == 4'h3) begin
              r_next.spt = byte_in;
            end
            if (idx == 4'h5) begin
              r_next.fill = byte_in;
            end
          end else if (r_reg.cmd[4:0] == OP_SEEK) begin
            if (idx == 4'h2) begin
              r_next.cyl = byte_in;
            end
            if (idx == 4'h1) begin
              // plain seek has no direction, keep it outward
              r_next.step_in = r_reg.cmd[BIT_REL_SEEK] & r_reg.cmd[BIT_REL_DIR];
            end
          end else if (r_reg.cmd[4:0] == OP_CONFIGURE && idx == 4'h2) begin
            r_next.seek_first = byte_in[BIT_SEEK_FIRST];
            r_next.queue_en_n = byte_in[BIT_QUEUE_EN_N];
          end else if (r_reg.cmd[4:0] == OP_PERP && idx == 4'h1) begin
            r_next.gap = byte_in[1:0];
            if (byte_in[BIT_OW]) begin
              r_next.perp = byte_in[POS_PERP_LO+1:POS_PERP_LO];
            end
          end
          if (idx == r_reg.pcnt) begin
            if (pinfo[4]) begin
              r_next.state = ST_EXEC;
              r_next.start = 1'b1;
              r_next.seek_req = r_reg.seek_first && is_rw(r_reg.cmd);
            end else begin
              r_next.state = ST_CMD;
            end
          end
        end
      end
      ST_EXEC: begin
        // status is kept until the host asks with sense interrupt
        if (exec_done) begin
          r_next.state = ST_CMD;
          r_next.irq = 1'b1;
          r_next.st0 = exec_st0;
        end
      end
      ST_RESULT: begin
        // single result byte: one read ends the phase
        if (result_rd) begin
          r_next.state = ST_CMD;
          r_next.irq = 1'b0;
          r_next.st0 = ST0_INVALID;
        end
      end
    endcase
    // ----------------------------------------
    // execution byte steering
    // ----------------------------------------
    // whole sector still passes the head; only the host side is cut
    // only read commands hand bytes to the host
    r_next.pass_host = is_read(r_reg.cmd) && ({1'b0, exec_byte_idx} < xfer_len);
    r_next.pad_zero = is_write(r_reg.cmd) && ({1'b0, exec_byte_idx} >= xfer_len);
    // one cycle late: the engine must allow for it at the last sector
    r_next.track_end = (cur_sector == r_reg.last_sec);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r_reg <= REGS_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // no byte is offered while the last one is still being taken apart
  assign request_for_master = (r_reg.state == ST_CMD || r_reg.state == ST_PARAM ||
                               r_reg.state == ST_RESULT) &&
                              !r_reg.busy;
  assign transfer_direction = (r_reg.state == ST_RESULT);
  assign result_byte = r_reg.st0;
  assign irq = r_reg.irq;
  assign cmd_start = r_reg.start;
  assign cmd_code = r_reg.cmd;
  assign implied_seek_req = r_reg.seek_req;

  // ----------------------------------------
  // parameter fields
  // ----------------------------------------
  assign cylinder = r_reg.cyl;
  assign drive_pick = r_reg.drive;
  assign drive_index = r_reg.drive[0];
  assign step_inward = r_reg.step_in;
  assign perp_drive_flags = r_reg.perp;
  assign gap2_adjust = r_reg.perp[r_reg.drive[0]] ? r_reg.gap : 2'b00;
  assign special_length_limit = r_reg.len_limit;
  assign sector_size_code = r_reg.n;
  assign sector_bytes = sect_len(r_reg.n);
  assign host_bytes = xfer_len;
  assign crc_bytes = sect_len(r_reg.n);
  assign count_mode_enable = r_reg.cnt_mode;
  assign sectors_per_track = r_reg.spt;
  assign queue_enable_low = r_reg.queue_en_n;
  assign implied_positioning_enable = r_reg.seek_first;
  assign final_sector_number = r_reg.last_sec;
  assign fill_pattern = r_reg.fill;
  assign exec_pass_host = r_reg.pass_host;
  assign exec_pad_zero = r_reg.pad_zero;
  assign track_end = r_reg.track_end;
endmodule : fcp_interp

// ===== hdl/fcp_pkg.sv
package fcp_pkg;
  // ----------------------------------------
  // command codes, low five bits of first byte
  // ----------------------------------------
  localparam logic [4:0] OP_READ_TRACK = 5'h02;
  localparam logic [4:0] OP_SPECIFY = 5'h03;
  localparam logic [4:0] OP_SENSE_DRV = 5'h04;
  localparam logic [4:0] OP_WRITE = 5'h05;
  localparam logic [4:0] OP_READ = 5'h06;
  localparam logic [4:0] OP_RECAL = 5'h07;
  localparam logic [4:0] OP_SENSE_INT = 5'h08;
  localparam logic [4:0] OP_WRITE_DEL = 5'h09;
  localparam logic [4:0] OP_READ_ID = 5'h0a;
  localparam logic [4:0] OP_READ_DEL = 5'h0c;
  localparam logic [4:0] OP_FORMAT = 5'h0d;
  localparam logic [4:0] OP_DUMPREG = 5'h0e;
  localparam logic [4:0] OP_SEEK = 5'h0f;
  localparam logic [4:0] OP_VERSION = 5'h10;
  localparam logic [4:0] OP_SCAN_EQ = 5'h11;
  localparam logic [4:0] OP_PERP = 5'h12;
  localparam logic [4:0] OP_CONFIGURE = 5'h13;
  localparam logic [4:0] OP_LOCK = 5'h14;
  localparam logic [4:0] OP_VERIFY = 5'h16;
  localparam logic [4:0] OP_SCAN_LE = 5'h19;
  localparam logic [4:0] OP_SCAN_HE = 5'h1d;
  // ----------------------------------------
  // parameter byte counts
  // ----------------------------------------
  localparam logic [3:0] CNT_RW = 4'h8;
  localparam logic [3:0] CNT_FORMAT = 4'h5;
  localparam logic [3:0] CNT_CONFIG = 4'h3;
  localparam logic [3:0] CNT_TWO = 4'h2;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_NONE = 4'h0;
  // ----------------------------------------
  // field positions and values
  // ----------------------------------------
  localparam int BIT_REL_DIR = 6;
  localparam int BIT_REL_SEEK = 7;
  localparam int BIT_CNT_MODE = 7;
  localparam int BIT_SEEK_FIRST = 6;
  localparam int BIT_QUEUE_EN_N = 5;
  localparam int BIT_OW = 7;
  localparam int POS_PERP_LO = 2;
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam logic [14:0] SECT_BASE = 15'h0080;
  localparam logic [2:0] N_MAX = 3'h7;
  localparam logic [7:0] LEN_LIMIT_RESET = 8'hff;
  localparam logic QUEUE_EN_LOW_RESET = 1'b1;
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_CMD = 4'b0001,
    ST_PARAM = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_RESULT = 4'b1000
  } fcp_state_e;
  typedef struct packed {
    fcp_state_e state;
    logic busy;
    logic [7:0] cmd;
    logic [3:0] pidx;
    logic [3:0] pcnt;
    logic irq;
    logic [7:0] st0;
    logic [7:0] cyl;
    logic [1:0] drive;
    logic step_in;
    logic [1:0] perp;
    logic [1:0] gap;
    logic [7:0] len_limit;
    logic [2:0] n;
    logic [7:0] last_sec;
    logic cnt_mode;
    logic queue_en_n;
    logic seek_first;
    logic [7:0] fill;
    logic [7:0] spt;
    logic start;
    logic seek_req;
    logic pass_host;
    logic pad_zero;
    logic track_end;
  } fcp_regs_s;
  localparam fcp_regs_s REGS_RESET = '{
    state: ST_CMD, busy: 1'b0, cmd: 8'h00, pidx: 4'h0, pcnt: 4'h0,
    irq: 1'b0, st0: ST0_INVALID, cyl: 8'h00, drive: 2'b00,
    step_in: 1'b0, perp: 2'b00, gap: 2'b00, len_limit: LEN_LIMIT_RESET, n: 3'h0,
    last_sec: 8'h00, cnt_mode: 1'b0, queue_en_n: QUEUE_EN_LOW_RESET, seek_first: 1'b0,
    fill: 8'h00, spt: 8'h00, start: 1'b0, seek_req: 1'b0,
    pass_host: 1'b0, pad_zero: 1'b0, track_end: 1'b0
  };
endpackage : fcp_pkg

// ===== verification/fcp_interp_asserts.sv
`timescale 1ns/1ps
module fcp_interp_asserts
  import fcp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic byte_wr,
  input wire logic result_rd,
  input wire logic [13:0] exec_byte_idx,
  input wire logic [7:0] cur_sector,
  input wire logic request_for_master,
  input wire logic transfer_direction,
  input wire logic irq,
  input wire logic cmd_start,
  input wire logic implied_seek_req,
  input wire logic [1:0] drive_pick,
  input wire logic drive_index,
  input wire logic [7:0] special_length_limit,
  input wire logic [2:0] sector_size_code,
  input wire logic [14:0] sector_bytes,
  input wire logic [14:0] host_bytes,
  input wire logic [14:0] crc_bytes,
  input wire logic implied_positioning_enable,
  input wire logic [7:0] final_sector_number,
  input wire logic exec_pass_host,
  input wire logic exec_pad_zero,
  input wire logic track_end
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_drive_index: assert property (drive_index == drive_pick[0])
    else $error("drive index does not follow drive pick");
  a_sector_len: assert property (sector_bytes == (SECT_BASE << sector_size_code))
    else $error("sector length wrong");
  a_crc_span: assert property (crc_bytes == sector_bytes)
    else $error("crc span differs from sector length");
  a_host_len: assert property (host_bytes == ((sector_size_code == 3'h0) ?
    {7'h00, special_length_limit} : sector_bytes)) else $error("host length wrong");
  // first edge after reset still sees reset-time inputs, so skip it
  a_track_last: assert property (rst_n && $past(rst_n) |->
    track_end == $past(cur_sector == final_sector_number)) else $error("track end wrong");
  a_pass_limit: assert property (exec_pass_host |->
    {1'b0, $past(exec_byte_idx)} < $past(host_bytes)) else $error("excess byte passed");
  a_pad_limit: assert property (exec_pad_zero |->
    {1'b0, $past(exec_byte_idx)} >= $past(host_bytes)) else $error("padding too early");
  a_byte_ack: assert property (byte_wr && request_for_master && !transfer_direction
    |=> !request_for_master) else $error("byte not acknowledged");
  a_seek_pair: assert property (implied_seek_req |-> cmd_start && implied_positioning_enable)
    else $error("implied seek without start or enable");
  a_result_clear: assert property (result_rd && request_for_master && transfer_direction
    |=> !irq && !transfer_direction) else $error("result read did not clear");
  c_start: cover property (cmd_start);
  c_irq: cover property ($rose(irq));
  c_track: cover property (track_end);
endmodule : fcp_interp_asserts

bind fcp_interp fcp_interp_asserts u_chk (.sys_clk, .rst_n, .byte_wr, .result_rd,
  .exec_byte_idx, .cur_sector, .request_for_master, .transfer_direction, .irq, .cmd_start,
  .implied_seek_req, .drive_pick, .drive_index, .special_length_limit, .sector_size_code,
  .sector_bytes, .host_bytes, .crc_bytes, .implied_positioning_enable, .final_sector_number,
  .exec_pass_host, .exec_pad_zero, .track_end);

// ===== verification/fcp_host_model.sv
`timescale 1ns/1ps
module fcp_host_model (
  input wire logic sys_clk,
  input wire logic request_for_master,
  input wire logic transfer_direction,
  input wire logic [7:0] result_byte,
  output logic byte_wr,
  output logic [7:0] byte_in,
  output logic result_rd
);
  initial begin
    byte_wr = 1'b0;
    byte_in = 8'h00;
    result_rd = 1'b0;
  end
  // bounded poll of the status flags, looked at 1 ns after each edge
  task automatic wait_flags(input logic dir);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (!(request_for_master === 1'b1 && transfer_direction === dir) && n < 60);
  endtask : wait_flags
  task automatic put(input logic [7:0] b);
    wait_flags(1'b0);
    byte_wr = 1'b1;
    byte_in = b;
    @(posedge sys_clk);
    #1;
    byte_wr = 1'b0;
    byte_in = ~b; // stale data shown inverted
  endtask : put
  task automatic get(output logic [7:0] r);
    wait_flags(1'b1);
    result_rd = 1'b1;
    // byte stands from here through the taking edge
    r = result_byte;
    @(posedge sys_clk);
    #1;
    result_rd = 1'b0;
  endtask : get
endmodule : fcp_host_model

// ===== verification/tb_floppy_command_params.sv
`timescale 1ns/1ps
module tb_floppy_command_params;
  import fcp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic byte_wr, result_rd, exec_done, request_for_master, transfer_direction, irq, cmd_start;
  logic implied_seek_req, drive_index, step_inward, count_mode_enable, queue_enable_low;
  logic implied_positioning_enable, exec_pass_host, exec_pad_zero, track_end;
  logic [7:0] byte_in, exec_st0, cur_sector, result_byte, cmd_code, cylinder;
  logic [7:0] special_length_limit, sectors_per_track, final_sector_number, fill_pattern;
  logic [1:0] drive_pick, perp_drive_flags, gap2_adjust;
  logic [2:0] sector_size_code;
  logic [13:0] exec_byte_idx = 14'h0000;
  logic [14:0] sector_bytes, host_bytes, crc_bytes;
  int bad_count = 0;
  int checks = 0;
  always #5 sys_clk = ~sys_clk;
  fcp_interp u_dut (.sys_clk, .rst_n, .byte_wr, .byte_in, .result_rd, .exec_done, .exec_st0,
    .exec_byte_idx, .cur_sector, .request_for_master, .transfer_direction, .result_byte, .irq,
    .cmd_start, .cmd_code, .implied_seek_req, .cylinder, .drive_pick, .drive_index,
    .step_inward, .perp_drive_flags, .gap2_adjust, .special_length_limit, .sector_size_code,
    .sector_bytes, .host_bytes, .crc_bytes, .count_mode_enable, .sectors_per_track,
    .queue_enable_low, .implied_positioning_enable, .final_sector_number, .fill_pattern,
    .exec_pass_host, .exec_pad_zero, .track_end);
  fcp_host_model u_host (.sys_clk, .request_for_master, .transfer_direction, .result_byte,
    .byte_wr, .byte_in, .result_rd);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [7:0] b [$]);
    foreach (b[i]) u_host.put(b[i]);
  endtask : send
  task automatic sense(input logic [7:0] exp);
    logic [7:0] r;
    u_host.put(8'h08);
    u_host.get(r);
    chk(r, exp);
    chk({irq, transfer_direction}, 2'b00);
  endtask : sense
  task automatic finish_exec(input logic [7:0] st);
    exec_st0 = st;
    exec_done = 1'b1;
    @(posedge sys_clk);
    #1;
    exec_done = 1'b0;
    sense(st);
  endtask : finish_exec
  // helper outputs are registered: one edge after the level changes
  task automatic probe(input logic [13:0] idx, input logic [7:0] sec);
    exec_byte_idx = idx;
    cur_sector = sec;
    @(posedge sys_clk);
    #1;
  endtask : probe
  task automatic finish_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk({request_for_master, transfer_direction, irq, queue_enable_low}, 4'b1001);
    chk({implied_positioning_enable, special_length_limit}, {1'b0, 8'hff});
    chk(result_byte, 8'h80);
    $display("test reset done");
  endtask : t_reset
  task automatic t_invalid();
    u_host.put(8'hff);
    chk({irq, request_for_master}, 2'b10);
    sense(ST0_INVALID);
    $display("test invalid done");
  endtask : t_invalid
  task automatic t_config();
    send('{8'h13, 8'h00, 8'h40, 8'h00});
    chk({implied_positioning_enable, queue_enable_low, irq}, 3'b100);
    $display("test configure done");
  endtask : t_config
  task automatic t_seek();
    send('{8'hcf, 8'h01, 8'hff});
    chk({cmd_start, implied_seek_req}, 2'b10);
    chk(cylinder, 8'hff);
    chk(cmd_code, 8'hcf);
    chk({drive_pick, drive_index, step_inward}, 4'b0111);
    finish_exec(8'h21);
    send('{8'h8f, 8'h00, 8'h00});
    chk({drive_pick, drive_index, step_inward, cylinder}, 12'h000);
    finish_exec(8'h20);
    $display("test seek done");
  endtask : t_seek
  task automatic t_read_write();
    send('{8'h06, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h09, 8'h1b, 8'h10});
    chk({cmd_start, implied_seek_req, final_sector_number}, {2'b11, 8'h09});
    chk(host_bytes, 16'h0010);
    probe(14'h000f, 8'h08);
    chk({exec_pass_host, track_end}, 2'b10);
    probe(14'h0010, 8'h09);
    chk({exec_pass_host, track_end}, 2'b01);
    finish_exec(8'h00);
    send('{8'h05, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h09, 8'h1b, 8'h10});
    probe(14'h0010, 8'h01);
    chk({exec_pad_zero, exec_pass_host}, 2'b10);
    probe(14'h000f, 8'h01);
    chk(exec_pad_zero, 1'b0);
    finish_exec(8'h01);
    send('{8'h06, 8'h01, 8'h05, 8'h00, 8'h01, 8'h01, 8'h09, 8'h1b, 8'hff});
    chk({sector_size_code, special_length_limit}, {3'h1, 8'hff});
    chk({host_bytes, drive_index}, {15'h0100, 1'b1});
    finish_exec(8'h04);
    $display("test read write done");
  endtask : t_read_write
  task automatic t_format_verify();
    send('{8'h0d, 8'h00, 8'h02, 8'h12, 8'h54, 8'ha5});
    chk(fill_pattern, 8'ha5);
    chk(sector_size_code, 3'h2);
    chk(sector_bytes, 16'h0200);
    chk(crc_bytes, 16'h0200);
    chk(host_bytes, 16'h0200);
    finish_exec(8'h02);
    send('{8'h16, 8'h80, 8'h00, 8'h00, 8'h01, 8'h02, 8'h09, 8'h1b, 8'h12});
    chk({count_mode_enable, sectors_per_track}, {1'b1, 8'h12});
    finish_exec(8'h03);
    send('{8'h12, 8'h86});
    chk({perp_drive_flags, gap2_adjust, irq}, 5'b01100);
    $display("test format verify done");
  endtask : t_format_verify
  task automatic t_other_cmds();
    send('{8'h03, 8'hdf, 8'h02});
    chk({cmd_start, irq, transfer_direction}, 3'b000);
    send('{8'h07, 8'h01});
    chk({cmd_start, implied_seek_req, drive_pick}, 4'b1001);
    finish_exec(8'h31);
    send('{8'h10});
    chk({cmd_code, irq}, {8'h10, 1'b0});
    // second reset in mid-run must bring configured fields back
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    chk({queue_enable_low, implied_positioning_enable, exec_pass_host}, 3'b100);
    $display("test other commands done");
  endtask : t_other_cmds
  initial begin
    exec_done = 1'b0;
    exec_st0 = 8'h00;
    cur_sector = 8'h00;
    repeat (5) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_invalid();
    t_config();
    t_seek();
    t_read_write();
    t_format_verify();
    t_other_cmds();
    finish_test();
  end
  // whole sequence needs about 180 cycles
  initial begin
    #200_000;
    bad_count++;
    finish_test();
  end
endmodule : tb_floppy_command_params
